/* pkg/cal_loader_pkg.sv */
package cal_loader_pkg;
  // Flash geometry
  localparam int          FLASH_AW       = 11;
  localparam int          PAGE_BYTES     = 512;
  localparam int          NUM_PAGES      = 4;
  // Table bases and fixed word locations
  localparam logic [10:0] OFFSET_TBL_BASE = 11'h000;
  localparam logic [10:0] OFFSET_TBL_LAST = 11'h15f;
  localparam logic [10:0] SPAN_TBL_BASE   = 11'h200;
  localparam logic [10:0] SETUP_A_ADDR    = 11'h160;
  localparam logic [10:0] SETUP_B_ADDR    = 11'h162;
  localparam logic [10:0] OFS_DRIFT_ADDR  = 11'h166;
  localparam logic [10:0] SPAN_DRIFT_ADDR = 11'h16a;
  localparam logic [10:0] PWRUP_ADDR      = 11'h16c;
  localparam logic [10:0] RESERVED_LO     = 11'h400;
  localparam logic [10:0] RESERVED_HI     = 11'h401;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  // Index clamp limits
  localparam logic [7:0]  INDEX_MIN       = 8'h00;
  localparam logic [7:0]  INDEX_MAX       = 8'haf;
  // Holding register slots
  localparam logic [2:0]  SLOT_OFFSET     = 3'h0;
  localparam logic [2:0]  SLOT_SPAN       = 3'h1;
  localparam logic [2:0]  SLOT_OFS_DRIFT  = 3'h2;
  localparam logic [2:0]  SLOT_SPAN_DRIFT = 3'h3;
  localparam logic [2:0]  SLOT_SETUP_A    = 3'h4;
  localparam logic [2:0]  SLOT_SETUP_B    = 3'h5;
  localparam int          NUM_SLOTS       = 6;
  // Setup word b fields
  localparam int          FAULT_EN_BIT    = 6;
  localparam int          REFRESH_LSB     = 0;
  localparam int          REFRESH_W       = 2;
  localparam logic [15:0] SETUP_RESET     = 16'h0000;
  // Timing
  localparam int          CLK_MHZ         = 100;
  localparam int          REFRESH_US      = 4000;
  localparam int          REFRESH_CYC     = REFRESH_US * CLK_MHZ;
  localparam int          LISTEN_US       = 2000;
  localparam int          LISTEN_CYC      = LISTEN_US * CLK_MHZ;
  // Fault thresholds in percent of bridge drive
  localparam int          FAULT_LO_PCT    = 20;
  localparam int          FAULT_HI_PCT    = 80;
  localparam int          PCT_FULL        = 100;
  // Fault clip code on the output path
  localparam logic [15:0] CLIP_LEVEL      = 16'h0100;
endpackage : cal_loader_pkg

/* rtl/index_clamp.sv */
`timescale 1ns/1ps
// Clamps raw temperature code and forms a table fetch address
module index_clamp
  import cal_loader_pkg::*;
(
  input  wire logic [7:0]  raw_code,
  input  wire logic [10:0] table_base,
  output logic      [7:0]  clamped,
  output logic      [10:0] fetch_addr
);
  // Codes above the top use the last entry; bottom is code zero
  always_comb begin
    if (raw_code > INDEX_MAX) begin
      clamped = INDEX_MAX;
    end else begin
      clamped = raw_code;
    end
    fetch_addr = table_base + {2'b00, clamped, 1'b0};
  end
endmodule : index_clamp

/* rtl/fault_detect.sv */
`timescale 1ns/1ps
// Window comparator on both sensor inputs against bridge drive
module fault_detect
  import cal_loader_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic [W-1:0] in_pos,
  input  wire logic [W-1:0] in_neg,
  input  wire logic [W-1:0] bridge_drive_voltage,
  input  wire logic         enable,
  output logic              fault
);
  logic [W+7:0] lo_lim, hi_lim, pos_s, neg_s;
  // Scale by 100 to compare percents without division
  always_comb begin
    lo_lim = (W+8)'(bridge_drive_voltage) * (W+8)'(FAULT_LO_PCT);
    hi_lim = (W+8)'(bridge_drive_voltage) * (W+8)'(FAULT_HI_PCT);
    pos_s  = (W+8)'(in_pos) * (W+8)'(PCT_FULL);
    neg_s  = (W+8)'(in_neg) * (W+8)'(PCT_FULL);
    fault  = enable && ((pos_s < lo_lim) || (pos_s > hi_lim) ||
                        (neg_s < lo_lim) || (neg_s > hi_lim));
  end
endmodule : fault_detect

/* rtl/temp_indexed_calibration_loader.sv */
`timescale 1ns/1ps
module temp_indexed_calibration_loader
  import cal_loader_pkg::*;
#(
  parameter int AW          = 12,
  parameter int LISTEN_CYCS = LISTEN_CYC,
  parameter int REFRESH_CYCS = REFRESH_CYC
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  // Flash read port, data in the same cycle as the address
  output logic [FLASH_AW-1:0]      flash_addr,
  output logic                     flash_rd,
  input  wire logic [7:0]          flash_data,
  // Temperature converter
  output logic                     temp_convert,
  input  wire logic [7:0]          temp_code,
  // Serial side
  input  wire logic                serial_activity,
  input  wire logic                serial_wr,
  input  wire logic [2:0]          serial_slot,
  input  wire logic [15:0]         serial_data,
  input  wire logic                go_analog,
  // Sensor inputs and drive, from the analog front end
  input  wire logic [AW-1:0]       in_pos,
  input  wire logic [AW-1:0]       in_neg,
  input  wire logic [AW-1:0]       bridge_drive_voltage,
  input  wire logic [15:0]         conditioned_signal,
  // Results
  output logic [15:0]              offset_trim_value,
  output logic [15:0]              span_trim_value,
  output logic [15:0]              offset_drift_coefficient,
  output logic [15:0]              span_drift_coefficient,
  output logic [15:0]              setup_word_a,
  output logic [15:0]              setup_word_b,
  output logic [7:0]               temperature_table_index,
  output logic                     analog_mode,
  output logic                     sensor_fault,
  output logic [15:0]              shared_output_pin
);

  typedef enum logic [2:0] {
    ST_LISTEN = 3'b000,
    ST_CAL    = 3'b001,
    ST_CONV   = 3'b011,
    ST_LO     = 3'b010,
    ST_HI     = 3'b110,
    ST_IDLE   = 3'b111
  } state_e;

  state_e         state_r;
  logic [31:0]    listen_cnt_r;
  logic [31:0]    refresh_cnt_r;
  logic [2:0]     slot_r;
  logic           full_load_r;
  logic [7:0]     low_byte_r;
  logic [15:0]    hold_r [NUM_SLOTS];
  logic [7:0]     clamped;
  logic [10:0]    ofs_addr, span_addr;
  logic [10:0]    word_addr;
  logic           fault_raw;
  logic [31:0]    period_cyc;
  logic           refresh_due;
  logic           word_done;
  logic [7:0]     index_nxt;
  logic [2:0]     slot_nxt;

  // Next slot and index, so the address flop leads the fetch by a cycle
  always_comb begin
    index_nxt = (state_r == ST_CONV) ? temp_code : temperature_table_index;
    case (state_r)
      ST_CONV: slot_nxt = full_load_r ? SLOT_SETUP_B : SLOT_SPAN;
      ST_HI:   slot_nxt = slot_r - 3'd1;
      default: slot_nxt = slot_r;
    endcase
  end

  // Index to address, one instance per table
  index_clamp u_ofs (
    .raw_code   (index_nxt),
    .table_base (OFFSET_TBL_BASE),
    .clamped    (clamped),
    .fetch_addr (ofs_addr)
  );
  index_clamp u_span (
    .raw_code   (index_nxt),
    .table_base (SPAN_TBL_BASE),
    .clamped    (),
    .fetch_addr (span_addr)
  );

  fault_detect #(.W(AW)) u_fault (
    .in_pos               (in_pos),
    .in_neg               (in_neg),
    .bridge_drive_voltage (bridge_drive_voltage),
    .enable               (hold_r[SLOT_SETUP_B][FAULT_EN_BIT]),
    .fault                (fault_raw)
  );

  // Word location for the slot fetched next
  always_comb begin
    case (slot_nxt)
      SLOT_OFFSET:     word_addr = ofs_addr;
      SLOT_SPAN:       word_addr = span_addr;
      SLOT_OFS_DRIFT:  word_addr = OFS_DRIFT_ADDR;
      SLOT_SPAN_DRIFT: word_addr = SPAN_DRIFT_ADDR;
      SLOT_SETUP_A:    word_addr = SETUP_A_ADDR;
      SLOT_SETUP_B:    word_addr = SETUP_B_ADDR;
      default:         word_addr = OFFSET_TBL_BASE;
    endcase
  end

  // Refresh period scales the nominal 4 ms by setup b field
  always_comb begin
    period_cyc  = REFRESH_CYCS <<
                  hold_r[SLOT_SETUP_B][REFRESH_LSB +: REFRESH_W];
    refresh_due = (refresh_cnt_r + 32'd1 >= period_cyc);
    word_done   = (state_r == ST_HI);
  end

  // Listening window after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      listen_cnt_r <= '0;
    end else if (state_r == ST_LISTEN) begin
      listen_cnt_r <= listen_cnt_r + 32'd1;
    end
  end

  // Refresh timer, only counts in analog idle
  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_IDLE || refresh_due) begin
      refresh_cnt_r <= '0;
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 32'd1;
    end
  end

  // Load sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r     <= ST_LISTEN;
      slot_r      <= SLOT_OFFSET;
      full_load_r <= 1'b0;
    end else begin
      case (state_r)
        ST_LISTEN: begin
          if (serial_activity) begin
            state_r <= ST_CAL;
          end else if (listen_cnt_r + 32'd1 >= 32'(LISTEN_CYCS)) begin
            state_r     <= ST_CONV;
            full_load_r <= 1'b1;
          end
        end
        ST_CAL: begin
          if (go_analog) begin
            state_r     <= ST_CONV;
            full_load_r <= 1'b1;
          end
        end
        ST_CONV: begin
          slot_r  <= slot_nxt;
          state_r <= ST_LO;
        end
        ST_LO: state_r <= ST_HI;
        ST_HI: begin
          if (slot_r == SLOT_OFFSET) begin
            state_r     <= ST_IDLE;
            full_load_r <= 1'b0;
          end else begin
            slot_r  <= slot_r - 3'd1;
            state_r <= ST_LO;
          end
        end
        ST_IDLE: begin
          if (refresh_due) begin
            state_r <= ST_CONV;
          end
        end
        default: state_r <= ST_LISTEN;
      endcase
    end
  end

  // Flash address drive, low byte at even then high at odd
  // Eleven address bits span the whole 2K array
  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_addr <= '0;
      flash_rd   <= 1'b0;
    end else if (state_r == ST_CONV ||
                 (state_r == ST_HI && slot_r != SLOT_OFFSET)) begin
      flash_rd   <= 1'b1;
      flash_addr <= word_addr; // Even byte of next word
    end else if (state_r == ST_LO) begin
      flash_rd   <= 1'b1;
      flash_addr <= word_addr | 11'h001;
    end else begin
      flash_rd   <= 1'b0;
      flash_addr <= flash_addr;
    end
  end

  // Index capture; converter strobe rises with the first fetch, on the same edge as capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      temperature_table_index <= INDEX_MIN;
      temp_convert            <= 1'b0;
    end else begin
      temp_convert <= (state_r == ST_CONV);
      if (state_r == ST_CONV) begin
        temperature_table_index <= temp_code;
      end
    end
  end

  // Byte pairing: low stored, register written with high byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_byte_r <= 8'h00;
    end else if (state_r == ST_LO) begin
      low_byte_r <= flash_data;
    end
  end

  // Holding registers; serial writes only in calibration mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        hold_r[i] <= SETUP_RESET;
      end
    end else if (word_done) begin
      hold_r[slot_r] <= {flash_data, low_byte_r};
    end else if (state_r == ST_CAL && serial_wr &&
                 serial_slot < 3'(NUM_SLOTS)) begin
      hold_r[serial_slot] <= serial_data;
    end
  end

  // Registered views of holding registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      offset_trim_value        <= SETUP_RESET;
      span_trim_value          <= SETUP_RESET;
      offset_drift_coefficient <= SETUP_RESET;
      span_drift_coefficient   <= SETUP_RESET;
      setup_word_a             <= SETUP_RESET;
      setup_word_b             <= SETUP_RESET;
      analog_mode              <= 1'b0;
    end else begin
      offset_trim_value        <= hold_r[SLOT_OFFSET];
      span_trim_value          <= hold_r[SLOT_SPAN];
      offset_drift_coefficient <= hold_r[SLOT_OFS_DRIFT];
      span_drift_coefficient   <= hold_r[SLOT_SPAN_DRIFT];
      setup_word_a             <= hold_r[SLOT_SETUP_A];
      setup_word_b             <= hold_r[SLOT_SETUP_B];
      analog_mode              <= state_r != ST_LISTEN &&
                                  state_r != ST_CAL;
    end
  end

  // Fault clip overrides the signal only in analog mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      sensor_fault      <= 1'b0;
      shared_output_pin <= 16'h0000;
    end else begin
      sensor_fault <= fault_raw;
      if (analog_mode && fault_raw) begin
        shared_output_pin <= CLIP_LEVEL;
      end else begin
        shared_output_pin <= conditioned_signal;
      end
    end
  end

  // Checks
  chk_index_clamped: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_LO |-> clamped <= INDEX_MAX)
    else $error("index above clamp");
  chk_listen_to_cal: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_LISTEN && serial_activity |=> state_r == ST_CAL)
    else $error("traffic did not hold calibration mode");
  chk_analog_loads: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_CAL && go_analog |=> state_r == ST_CONV ##1
    slot_r == SLOT_SETUP_B)
    else $error("switch to analog did not reload");
  chk_pair_update: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_LO |=> state_r == ST_HI ##1
    hold_r[$past(slot_r)] == {$past(flash_data), $past(low_byte_r)})
    else $error("word not assembled from two bytes");
  chk_fault_clip: assert property (@(posedge mclk) disable iff (reset)
    analog_mode && fault_raw |=> shared_output_pin == CLIP_LEVEL)
    else $error("fault did not clip output");
  chk_fault_gate: assert property (@(posedge mclk) disable iff (reset)
    !hold_r[SLOT_SETUP_B][FAULT_EN_BIT] |=> !sensor_fault)
    else $error("fault raised while disabled");
  chk_refresh_go: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_IDLE && refresh_due |=> state_r == ST_CONV ##1
    temp_convert)
    else $error("refresh did not restart conversion");
  chk_ofs_addr: assert property (@(posedge mclk) disable iff (reset)
    ofs_addr <= OFFSET_TBL_LAST - 11'h001)
    else $error("offset fetch beyond table");
  chk_no_serial_analog: assert property (@(posedge mclk)
    disable iff (reset)
    state_r == ST_IDLE && serial_wr |=> $stable(hold_r[serial_slot]))
    else $error("serial write in analog mode");
  chk_even_then_odd: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_LO |-> !flash_addr[0] ##1 flash_addr[0])
    else $error("word bytes fetched out of order");
  chk_refresh_span: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_CONV && !full_load_r |=> slot_r == SLOT_SPAN)
    else $error("refresh skipped span word");
  chk_listen_expiry: assert property (@(posedge mclk) disable iff (reset)
    state_r == ST_LISTEN && !serial_activity &&
    listen_cnt_r + 32'd1 >= 32'(LISTEN_CYCS) |=> state_r == ST_CONV)
    else $error("listen window did not expire");
  cov_cal_entry: cover property (@(posedge mclk) state_r == ST_CAL);
  cov_full_load: cover property (@(posedge mclk)
    full_load_r && word_done && slot_r == SLOT_OFFSET);
  cov_refresh:   cover property (@(posedge mclk)
    !full_load_r && word_done && slot_r == SLOT_OFFSET);
  cov_clip:      cover property (@(posedge mclk)
    shared_output_pin == CLIP_LEVEL && analog_mode);
endmodule : temp_indexed_calibration_loader

/* test/flash_model.sv */
`timescale 1ns/1ps
// Byte-wide flash array, data in the same cycle as the address
module flash_model
  import cal_loader_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [10:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [7:0]  flash_data
);
  logic [7:0]  mem [0:PAGE_BYTES*NUM_PAGES-1];
  logic [7:0]  last_r = 8'h00;

  // Pattern contents; setup b enables fault check, shortest period
  // Reserved pair is filled once and never altered
  initial begin
    for (int a = 0; a < PAGE_BYTES*NUM_PAGES; a++) begin
      mem[a] = 8'(a) ^ {2'(a >> 9), 6'h2a};
    end
    mem[SETUP_B_ADDR]      = 8'h40;
    mem[SETUP_B_ADDR + 1]  = 8'h00;
  end

  // Remember the byte last shown, for the idle bus below
  always_ff @(posedge mclk) begin
    if (flash_rd) begin
      last_r <= mem[flash_addr];
    end
  end

  // Byte for the registered address stands through the cycle
  // Idle bus shows inverted old byte so stale data never matches
  assign flash_data = flash_rd ? mem[flash_addr] : ~last_r;
endmodule : flash_model

/* test/temp_indexed_calibration_loader_test.sv */
`timescale 1ns/1ps
module temp_indexed_calibration_loader_test;
  import cal_loader_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, flash_rd, temp_convert;
  logic        serial_activity = 1'b0, serial_wr = 1'b0, go_analog = 1'b0;
  logic [10:0] flash_addr;
  logic [7:0]  flash_data, temperature_table_index;
  logic [7:0]  temp_code = 8'h10;
  logic [2:0]  serial_slot = 3'h0;
  logic [15:0] serial_data = 16'h0000, conditioned_signal = 16'h1234;
  logic [11:0] in_pos = 12'd2000, in_neg = 12'd2000, bdv = 12'd4000;
  logic [15:0] ofs, spn, odr, sdr, sua, sub, pin;
  logic        analog_mode, sensor_fault;
  int          n_errors = 0, tests_run = 0;

  always #5 mclk = ~mclk;

  flash_model i_flash_model (.mclk(mclk), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_data(flash_data));

  temp_indexed_calibration_loader #(.LISTEN_CYCS(50), .REFRESH_CYCS(40))
  i_temp_indexed_calibration_loader (.mclk(mclk), .reset(reset),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_data(flash_data),
    .temp_convert(temp_convert), .temp_code(temp_code),
    .serial_activity(serial_activity), .serial_wr(serial_wr),
    .serial_slot(serial_slot), .serial_data(serial_data),
    .go_analog(go_analog), .in_pos(in_pos), .in_neg(in_neg),
    .bridge_drive_voltage(bdv), .conditioned_signal(conditioned_signal),
    .offset_trim_value(ofs), .span_trim_value(spn),
    .offset_drift_coefficient(odr), .span_drift_coefficient(sdr),
    .setup_word_a(sua), .setup_word_b(sub),
    .temperature_table_index(temperature_table_index),
    .analog_mode(analog_mode), .sensor_fault(sensor_fault),
    .shared_output_pin(pin));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  // Word as stored: low byte even, high byte next
  function automatic logic [15:0] word_at(input logic [10:0] a);
    return {i_flash_model.mem[a + 11'h1], i_flash_model.mem[a]};
  endfunction : word_at

  function automatic logic [10:0] tbl(input logic [10:0] b,
                                      input logic [7:0] c);
    logic [7:0] k;
    k = (c > INDEX_MAX) ? INDEX_MAX : c;
    return b + {2'h0, k, 1'b0};
  endfunction : tbl

  function automatic logic [15:0] slot_val(input int s);
    case (s)
      0: return ofs;
      1: return spn;
      2: return odr;
      3: return sdr;
      4: return sua;
      default: return sub;
    endcase
  endfunction : slot_val

  task automatic do_reset(input logic act);
    @(posedge mclk);
    reset <= 1'b1;
    serial_activity <= act;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset

  // Bounded wait for analog mode, then let the load sequence land
  task automatic wait_analog();
    int n;
    for (n = 0; n < 300 && analog_mode !== 1'b1; n++) @(posedge mclk);
    if (n >= 300) begin
      n_errors++;
      $display("[ERR] analog_mode exp 1 got %b", analog_mode);
      end_sim();
    end
    repeat (20) @(posedge mclk);
  endtask : wait_analog

  task automatic chk_full_load(input logic [7:0] c);
    chk("offset", word_at(tbl(OFFSET_TBL_BASE, c)), ofs);
    chk("span", word_at(tbl(SPAN_TBL_BASE, c)), spn);
    chk("setup_a", word_at(SETUP_A_ADDR), sua);
    chk("setup_b", word_at(SETUP_B_ADDR), sub);
    chk("ofs_drift", word_at(OFS_DRIFT_ADDR), odr);
    chk("span_drift", word_at(SPAN_DRIFT_ADDR), sdr);
  endtask : chk_full_load

  task automatic scen_listen_timeout();
    do_reset(1'b0);
    repeat (40) @(posedge mclk);
    chk("early_mode", 16'h0, {15'h0, analog_mode});
    wait_analog();
    chk_full_load(8'h10);
  endtask : scen_listen_timeout

  // Codes across both clamp limits, waiting past two refresh periods
  task automatic scen_refresh();
    logic [7:0] codes [5] = '{8'h00, 8'h5a, 8'hae, 8'haf, 8'hff};
    foreach (codes[i]) begin
      @(posedge mclk);
      temp_code <= codes[i];
      repeat (100) @(posedge mclk);
      chk("index", {8'h0, codes[i]}, {8'h0, temperature_table_index});
      chk("ref_ofs", word_at(tbl(OFFSET_TBL_BASE, codes[i])), ofs);
      chk("ref_span", word_at(tbl(SPAN_TBL_BASE, codes[i])), spn);
    end
    chk("clamp_hi", word_at(OFFSET_TBL_LAST - 11'h1), ofs);
    @(posedge mclk);
    temp_code <= INDEX_MIN;
    repeat (100) @(posedge mclk);
    chk("clamp_lo", word_at(OFFSET_TBL_BASE), ofs);
  endtask : scen_refresh

  task automatic scen_fault();
    int lo [3] = '{700, 2000, 2000};
    int hi [3] = '{2000, 3300, 2000};
    logic [15:0] exp;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      in_pos <= 12'(lo[i]);
      in_neg <= 12'(hi[i]);
      repeat (4) @(posedge mclk);
      exp = (i < 2) ? CLIP_LEVEL : conditioned_signal;
      chk("fault", {15'h0, i < 2}, {15'h0, sensor_fault});
      chk("out_pin", exp, pin);
    end
  endtask : scen_fault

  task automatic ser_wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge mclk);
    serial_wr <= 1'b1;
    serial_slot <= s;
    serial_data <= d;
    @(posedge mclk);
    serial_wr <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : ser_wr

  task automatic scen_calibration();
    do_reset(1'b1);
    repeat (200) @(posedge mclk);
    chk("cal_mode", 16'h0, {15'h0, analog_mode});
    for (int s = 0; s < NUM_SLOTS; s++) begin
      ser_wr(3'(s), 16'h1100 + 16'(s));
      chk("slot", 16'h1100 + 16'(s), slot_val(s));
    end
    ser_wr(3'h6, 16'hbeef);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      chk("bad_slot", 16'h1100 + 16'(s), slot_val(s));
    end
    @(posedge mclk);
    in_pos <= 12'd700;
    repeat (4) @(posedge mclk);
    chk("fault_off", 16'h0, {15'h0, sensor_fault});
    ser_wr(SLOT_SETUP_B, 16'h0040);
    chk("cal_fault", 16'h1, {15'h0, sensor_fault});
    chk("cal_pin", conditioned_signal, pin);
    @(posedge mclk);
    in_pos <= 12'd2000;
    @(posedge mclk);
    temp_code <= 8'hc0;
    go_analog <= 1'b1;
    @(posedge mclk);
    go_analog <= 1'b0;
    wait_analog();
    chk_full_load(8'hc0);
    ser_wr(SLOT_SETUP_A, 16'hdead);
    chk("refused", word_at(SETUP_A_ADDR), sua);
  endtask : scen_calibration

  initial begin
    scen_listen_timeout();
    scen_refresh();
    scen_fault();
    scen_calibration();
    end_sim();
  end
endmodule : temp_indexed_calibration_loader_test
